// ===== rtl/asd_pkg.sv
// Package for the add/subtract/decimal-adjust datapath.
// Assumes a single processor clock domain; no software-visible registers.
package asd_pkg;

  localparam int ASD_BYTE_W = 8;
  localparam int ASD_WORD_W = 16;
  localparam int ASD_NIB_W = 4;
  localparam int ASD_LATENCY = 1;

  // Positions of the flags in the packed flag word
  localparam int ASD_FLAG_W = 6;
  localparam int ASD_FL_CARRY = 0;
  localparam int ASD_FL_PARITY = 1;
  localparam int ASD_FL_HALF = 2;
  localparam int ASD_FL_ZERO = 3;
  localparam int ASD_FL_SIGN = 4;
  localparam int ASD_FL_OVF = 5;
  localparam logic [5:0] ASD_FLAGS_RST = 6'h00;

  localparam logic [3:0] ASD_NIB_MAX = 4'h9;
  localparam logic [7:0] ASD_PACK_HI_MAX = 8'h99;
  localparam logic [7:0] ASD_LO_FIX = 8'h06;
  localparam logic [7:0] ASD_HI_FIX = 8'h60;
  localparam logic [15:0] ASD_RES_RST = 16'h0000;

  typedef enum logic [3:0] {
    ASD_OP_ADD = 4'h0,
    ASD_OP_ADC = 4'h1,
    ASD_OP_INC = 4'h2,
    ASD_OP_UNPACKED_SUM_ADJUST = 4'h3,
    ASD_OP_PACKED_SUM_ADJUST = 4'h4,
    ASD_OP_SUB = 4'h5,
    ASD_OP_DIFFERENCE_WITH_BORROW_IN = 4'h6,
    ASD_OP_MINUS_ONE = 4'h7,
    ASD_OP_TWOS_COMPLEMENT = 4'h8,
    ASD_OP_COMPARE = 4'h9
  } asd_op_t;

endpackage : asd_pkg

// ===== rtl/asd_adder.sv
// Width-generic add/subtract core with carry, half-carry and overflow.
// Purely combinational; the caller registers everything.
`timescale 1ns/1ps
module asd_adder #(
  parameter int W = 16
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic cin_i,
  input wire logic sub_i,
  output logic [W-1:0] sum_o,
  output logic carry_o,
  output logic half_o,
  output logic ovf_o
);
  logic [W-1:0] b_eff;
  logic [W:0] full;
  logic [4:0] nib;

  // Subtraction adds the inverted operand; the borrow is the inverted carry
  assign b_eff = sub_i ? ~b_i : b_i;
  assign full = {1'b0, a_i} + {1'b0, b_eff} + {{W{1'b0}}, (cin_i ^ sub_i)};
  assign nib = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, (cin_i ^ sub_i)};
  assign sum_o = full[W-1:0];
  assign carry_o = full[W] ^ sub_i;
  assign half_o = nib[4] ^ sub_i;
  assign ovf_o = (a_i[W-1] == b_eff[W-1]) && (sum_o[W-1] != a_i[W-1]);

endmodule : asd_adder

// ===== rtl/asd_flags.sv
// Sign, zero and parity evaluation for a byte or word result.
// Purely combinational.
`timescale 1ns/1ps
module asd_flags
  import asd_pkg::*;
(
  input wire logic [15:0] res_i,
  input wire logic word_i,
  output logic sign_o,
  output logic zero_o,
  output logic parity_o
);
  assign sign_o = word_i ? res_i[ASD_WORD_W-1] : res_i[ASD_BYTE_W-1];
  assign zero_o = word_i ? (res_i == 16'h0000) : (res_i[7:0] == 8'h00);
  // Parity always looks at the low byte, even for words
  assign parity_o = ~(^res_i[ASD_BYTE_W-1:0]);

endmodule : asd_flags

// ===== rtl/asd_alu.sv
// Add/subtract/decimal-adjust datapath with six status flags.
// Driven by the instruction sequencer; one-cycle latency from op_valid_i.
//
// Operation
// - Signed operands are two's complement, top bit of byte or word is sign.
// - Packed decimal byte holds two digits 0-9, upper nibble most significant.
// - Unpacked decimal digit comes from low nibble only; upper nibble ignored.
// - Carry set on carry out of, or borrow into, the top bit.
// - Half-carry set on carry out of, or borrow into, the low nibble.
// - Sign equals bit 7 for bytes, bit 15 for words.
// - Zero set when whole result is zero.
// - Parity set when low eight result bits hold even count of ones.
// - Overflow set when signed result leaves destination range.
// - Add writes sum and updates all six flags.
// - Add-with-carry adds carry in, writes result, updates all six flags.
// - Increment adds one, updates five flags, keeps carry.
// - Unpacked adjust fixes low byte, zeroes upper nibble, updates carry, half-carry.
// - Packed adjust fixes low byte to two digits; overflow left undefined.
// - Subtract writes destination minus source, updates all six flags.
// - Subtract-with-borrow also subtracts carry; updates all six flags.
// - Decrement subtracts one, updates five flags, keeps carry.
// - Negate forms zero minus value; most negative stays, sets overflow.
// - Negate updates all flags; carry set unless operand is zero.
// - Compare sets flags as subtract but writes nothing back.
`timescale 1ns/1ps
module asd_alu
  import asd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic op_valid_i,
  input wire asd_op_t op_i,
  input wire logic word_i,
  input wire logic [15:0] dst_i,
  input wire logic [15:0] src_i,
  input wire logic [7:0] accumulator_low_byte_i,
  output logic [15:0] result_o,
  output logic result_we_o,
  output logic done_o,
  output logic carry_bit_o,
  output logic half_carry_bit_o,
  output logic sign_bit_o,
  output logic zero_bit_o,
  output logic parity_bit_o,
  output logic overflow_bit_o
);

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic op_cin;
  logic op_sub;

  always_comb begin
    op_a = dst_i;
    op_b = src_i;
    op_cin = 1'b0;
    op_sub = 1'b0;
    unique case (op_i)
      ASD_OP_ADD: begin
      end
      ASD_OP_ADC: begin
        op_cin = carry_bit_o;
      end
      ASD_OP_INC: begin
        op_b = 16'h0001;
      end
      ASD_OP_SUB, ASD_OP_COMPARE: begin
        op_sub = 1'b1;
      end
      ASD_OP_DIFFERENCE_WITH_BORROW_IN: begin
        op_sub = 1'b1;
        op_cin = carry_bit_o;
      end
      ASD_OP_MINUS_ONE: begin
        op_sub = 1'b1;
        op_b = 16'h0001;
      end
      ASD_OP_TWOS_COMPLEMENT: begin
        op_a = 16'h0000;
        op_b = dst_i;
        op_sub = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // ****************************************************************
  // Arithmetic core
  // ****************************************************************
  logic [15:0] sum_w;
  logic [15:0] sum_b;
  logic c_w;
  logic h_w;
  logic v_w;
  logic c_b;
  logic h_b;
  logic v_b;

  asd_adder #(.W(ASD_WORD_W)) u_word (
    .a_i(op_a),
    .b_i(op_b),
    .cin_i(op_cin),
    .sub_i(op_sub),
    .sum_o(sum_w),
    .carry_o(c_w),
    .half_o(h_w),
    .ovf_o(v_w)
  );

  // Byte lane: low byte of the operands on a second adder keeps nibble carry exact
  asd_adder #(.W(ASD_WORD_W)) u_byte (
    .a_i({8'h00, op_a[7:0]}),
    .b_i({8'h00, op_b[7:0]}),
    .cin_i(op_cin),
    .sub_i(op_sub),
    .sum_o(sum_b),
    .carry_o(),
    .half_o(h_b),
    .ovf_o()
  );

  // Carry and overflow of a byte taken from its own 9-bit sum,
  // so that a carry-in or borrow-in reaches the byte's top bit exactly
  logic [8:0] byte_full;
  logic [7:0] bb;
  assign bb = op_sub ? ~op_b[7:0] : op_b[7:0];
  assign byte_full = {1'b0, op_a[7:0]} + {1'b0, bb} + {8'h00, (op_cin ^ op_sub)};
  assign c_b = byte_full[8] ^ op_sub;
  assign v_b = (op_a[7] == bb[7]) && (byte_full[7] != op_a[7]);

  logic [15:0] bin_res;
  logic bin_c;
  logic bin_h;
  logic bin_v;
  assign bin_res = word_i ? sum_w : {8'h00, sum_b[7:0]};
  assign bin_c = word_i ? c_w : c_b;
  assign bin_h = word_i ? h_w : h_b;
  assign bin_v = word_i ? v_w : v_b;

  // ****************************************************************
  // Decimal adjust on the low accumulator byte
  // ****************************************************************
  logic [7:0] acc;
  logic lo_fix;
  logic [7:0] unp_res;
  logic [7:0] pk_lo;
  logic pk_hi_fix;
  logic [7:0] pk_res;

  assign acc = accumulator_low_byte_i;
  // Only the low nibble carries the unpacked digit
  assign lo_fix = (acc[3:0] > ASD_NIB_MAX) || half_carry_bit_o;
  assign unp_res = {4'h0, 4'(acc[3:0] + (lo_fix ? 4'h6 : 4'h0))};
  assign pk_lo = lo_fix ? 8'(acc + ASD_LO_FIX) : acc;
  assign pk_hi_fix = (acc > ASD_PACK_HI_MAX) || carry_bit_o;
  assign pk_res = pk_hi_fix ? 8'(pk_lo + ASD_HI_FIX) : pk_lo;

  // ****************************************************************
  // Result and flag selection
  // ****************************************************************
  logic [15:0] next_result;
  logic next_we;
  logic next_word;
  logic next_c;
  logic next_h;
  logic next_v;
  logic upd_c;
  logic upd_szp;
  logic upd_v;
  logic negate_min;

  assign negate_min = word_i ? (dst_i == 16'h8000) : (dst_i[7:0] == 8'h80);

  always_comb begin
    next_result = bin_res;
    next_we = 1'b1;
    next_word = word_i;
    next_c = bin_c;
    next_h = bin_h;
    next_v = bin_v;
    upd_c = 1'b1;
    upd_szp = 1'b1;
    upd_v = 1'b1;
    unique case (op_i)
      ASD_OP_INC, ASD_OP_MINUS_ONE: begin
        upd_c = 1'b0;
      end
      ASD_OP_COMPARE: begin
        next_we = 1'b0;
      end
      ASD_OP_TWOS_COMPLEMENT: begin
        next_c = word_i ? (dst_i != 16'h0000) : (dst_i[7:0] != 8'h00);
        next_v = negate_min;
      end
      ASD_OP_UNPACKED_SUM_ADJUST: begin
        next_result = {8'h00, unp_res};
        next_word = 1'b0;
        next_c = lo_fix;
        next_h = lo_fix;
        upd_szp = 1'b0;
        upd_v = 1'b0;
      end
      ASD_OP_PACKED_SUM_ADJUST: begin
        next_result = {8'h00, pk_res};
        next_word = 1'b0;
        next_c = pk_hi_fix;
        next_h = lo_fix;
        upd_v = 1'b0;
      end
      default: begin
      end
    endcase
  end

  logic s_n;
  logic z_n;
  logic p_n;
  asd_flags u_flags (
    .res_i(next_result),
    .word_i(next_word),
    .sign_o(s_n),
    .zero_o(z_n),
    .parity_o(p_n)
  );

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= ASD_RES_RST;
      result_we_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= op_valid_i;
      result_we_o <= op_valid_i && next_we;
      if (op_valid_i && next_we) begin
        result_o <= next_result;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_bit_o <= 1'b0;
      half_carry_bit_o <= 1'b0;
      sign_bit_o <= 1'b0;
      zero_bit_o <= 1'b0;
      parity_bit_o <= 1'b0;
      overflow_bit_o <= 1'b0;
    end else if (op_valid_i) begin
      // Adjusts leave some flags undefined; those hold, so runs repeat exactly
      half_carry_bit_o <= next_h;
      if (upd_c) begin
        carry_bit_o <= next_c;
      end
      if (upd_szp) begin
        sign_bit_o <= s_n;
        zero_bit_o <= z_n;
        parity_bit_o <= p_n;
      end
      if (upd_v) begin
        overflow_bit_o <= next_v;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_SIGN: assert property (op_valid_i && upd_szp |=>
    sign_bit_o == ($past(next_word) ? result_o[15] : result_o[7]) || !result_we_o)
    else $error("sign flag does not follow result top bit");
  AST_PARITY: assert property (op_valid_i && next_we && upd_szp |=>
    parity_bit_o == ~(^result_o[7:0]))
    else $error("parity flag wrong");
  AST_ZERO: assert property (op_valid_i && next_we && upd_szp && word_i
    && op_i != ASD_OP_PACKED_SUM_ADJUST |=> zero_bit_o == (result_o == 16'h0000))
    else $error("zero flag wrong");
  AST_INC_KEEPS_CARRY: assert property (op_valid_i && (op_i == ASD_OP_INC
    || op_i == ASD_OP_MINUS_ONE) |=> $stable(carry_bit_o))
    else $error("carry changed by increment or decrement");
  AST_COMPARE_NO_WRITE: assert property (op_valid_i && op_i == ASD_OP_COMPARE |=>
    !result_we_o && $stable(result_o))
    else $error("compare wrote a result");
  AST_NEGATE_CARRY: assert property (op_valid_i && op_i == ASD_OP_TWOS_COMPLEMENT && word_i |=>
    carry_bit_o == (result_o != 16'h0000))
    else $error("negate carry wrong");
  AST_NEGATE_MIN: assert property (op_valid_i && negate_min
    && op_i == ASD_OP_TWOS_COMPLEMENT |=> overflow_bit_o
    && result_o == ($past(word_i) ? $past(dst_i) : ($past(dst_i) & 16'h00ff)))
    else $error("negate of most negative wrong");
  AST_ADD_WORD: assert property (op_valid_i && op_i == ASD_OP_ADD && word_i |=>
    {carry_bit_o, result_o} == 17'($past(dst_i)) + 17'($past(src_i)))
    else $error("word add result or carry wrong");
  AST_UNPACKED_HI: assert property (op_valid_i && op_i == ASD_OP_UNPACKED_SUM_ADJUST |=>
    result_o[15:4] == 12'h000 && $stable(overflow_bit_o))
    else $error("unpacked adjust upper nibble not zero");
  AST_DONE: assert property (op_valid_i |=> done_o)
    else $error("done missing");

  // Results against plain operators on the operands of the taking edge
  AST_ADC_WORD: assert property (op_valid_i && op_i == ASD_OP_ADC && word_i |=>
    {carry_bit_o, result_o} == 17'($past(dst_i)) + 17'($past(src_i)) + 17'($past(carry_bit_o)))
    else $error("word add-with-carry result or carry wrong");
  AST_SUB_BYTE: assert property (op_valid_i && op_i == ASD_OP_SUB && !word_i |=>
    result_o == {8'h00, 8'($past(dst_i) - $past(src_i))})
    else $error("byte subtract result wrong");
  AST_BORROW_WORD: assert property (op_valid_i && word_i
    && op_i == ASD_OP_DIFFERENCE_WITH_BORROW_IN
    |=> result_o == 16'($past(dst_i) - $past(src_i) - {15'h0, $past(carry_bit_o)}))
    else $error("word subtract-with-borrow result wrong");
  AST_MINUS_ONE_WORD: assert property (op_valid_i && op_i == ASD_OP_MINUS_ONE
    && word_i |=> result_o == 16'($past(dst_i) - 16'h0001)
    && overflow_bit_o == ($past(dst_i) == 16'h8000))
    else $error("word decrement result or overflow wrong");
  AST_UNPACKED_FLAGS: assert property (op_valid_i
    && op_i == ASD_OP_UNPACKED_SUM_ADJUST |=> carry_bit_o == half_carry_bit_o
    && $stable(sign_bit_o) && $stable(zero_bit_o) && $stable(parity_bit_o))
    else $error("unpacked adjust flags wrong");
  AST_PACKED_KEEPS_OVF: assert property (op_valid_i
    && op_i == ASD_OP_PACKED_SUM_ADJUST |=> $stable(overflow_bit_o) && result_o[15:8] == 8'h00)
    else $error("packed adjust disturbed overflow or upper byte");
  AST_WE_PULSE: assert property (op_valid_i && op_i != ASD_OP_COMPARE
    |=> result_we_o)
    else $error("result write enable missing");
  AST_IDLE_QUIET: assert property (!op_valid_i |=> !done_o && !result_we_o)
    else $error("pulse without an operation");

  COV_ADC: cover property (op_valid_i && op_i == ASD_OP_ADC && carry_bit_o);
  COV_NEGATE_MIN: cover property (op_valid_i && op_i == ASD_OP_TWOS_COMPLEMENT && negate_min);
  COV_BORROW_CHAIN: cover property (op_valid_i && carry_bit_o
    && op_i == ASD_OP_DIFFERENCE_WITH_BORROW_IN);
  COV_COMPARE: cover property (op_valid_i && op_i == ASD_OP_COMPARE);
  COV_PACKED: cover property (op_valid_i && op_i == ASD_OP_PACKED_SUM_ADJUST && pk_hi_fix);

endmodule : asd_alu

// ===== tb/asd_seq_model.sv
// Sequencer and register-file stand-in that feeds the datapath.
// Assumes the bench calls drive() right after a rising clock edge.
`timescale 1ns/1ps
module asd_seq_model
  import asd_pkg::*;
(
  input wire logic clk_i,
  input wire logic [15:0] result_i,
  input wire logic result_we_i,
  output logic op_valid_o,
  output asd_op_t op_o,
  output logic word_o,
  output logic [15:0] dst_o,
  output logic [15:0] src_o,
  output logic [7:0] acc_o
);
  // ****************
  // Write-back slot
  // ****************
  logic [15:0] wb_reg;

  initial begin
    op_valid_o = 1'b0;
    op_o = ASD_OP_ADD;
    word_o = 1'b0;
    dst_o = 16'h0000;
    src_o = 16'h0000;
    acc_o = 8'h00;
    wb_reg = 16'h0000;
  end

  always @(posedge clk_i) begin
    if (result_we_i) begin
      wb_reg <= result_i;
    end
  end

  // Idle cycles flip the operand lines so nothing can lean on stale values
  task automatic drive(logic v, asd_op_t op, logic w, logic [15:0] d, logic [15:0] s,
                       logic [7:0] lb);
    op_valid_o <= v;
    op_o <= op;
    word_o <= w;
    dst_o <= v ? d : ~dst_o;
    src_o <= v ? s : ~src_o;
    acc_o <= v ? lb : ~acc_o;
  endtask : drive
endmodule : asd_seq_model

// ===== tb/test_add_sub_decimal_alu_flags.sv
// Self-checking bench for the add/subtract/decimal-adjust datapath.
// Assumes one-cycle latency and the flag packing order of the package.
`timescale 1ns/1ps
module test_add_sub_decimal_alu_flags;
  import asd_pkg::*;
  logic clk_i, rst_n_i, op_valid, word, we, done;
  logic carry_bit, half_carry_bit, sign_bit, zero_bit, parity_bit, overflow_bit;
  asd_op_t op;
  logic [15:0] dst, src, res;
  logic [7:0] acc;
  logic [5:0] exp_f;
  logic [15:0] exp_r;
  logic pend, pend_we;
  int error_cnt, n_checks;
  wire [5:0] fl = {overflow_bit, sign_bit, zero_bit, half_carry_bit, parity_bit, carry_bit};

  asd_seq_model seq (.clk_i(clk_i), .result_i(res), .result_we_i(we), .op_valid_o(op_valid),
    .op_o(op), .word_o(word), .dst_o(dst), .src_o(src), .acc_o(acc));
  asd_alu dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid), .op_i(op),
    .word_i(word), .dst_i(dst), .src_i(src), .accumulator_low_byte_i(acc), .result_o(res),
    .result_we_o(we), .done_o(done), .carry_bit_o(carry_bit),
    .half_carry_bit_o(half_carry_bit), .sign_bit_o(sign_bit), .zero_bit_o(zero_bit),
    .parity_bit_o(parity_bit), .overflow_bit_o(overflow_bit));

  // ****************
  // Reference model
  // ****************
  function automatic logic [21:0] ref_op(asd_op_t o, logic w, logic [15:0] d, logic [15:0] s,
                                         logic [7:0] lb, logic [5:0] f, logic [15:0] r0);
    logic [16:0] x;
    logic [15:0] m, a, b, r;
    logic ci, ad, lo, hi;
    logic [5:0] n;
    int t;
    m = w ? 16'hffff : 16'h00ff;
    t = w ? 15 : 7;
    n = f;
    a = d & m;
    b = s & m;
    ci = 1'b0;
    ad = (o == ASD_OP_ADD || o == ASD_OP_ADC || o == ASD_OP_INC || o > ASD_OP_COMPARE);
    if (o == ASD_OP_ADC || o == ASD_OP_DIFFERENCE_WITH_BORROW_IN) ci = f[ASD_FL_CARRY];
    if (o == ASD_OP_INC || o == ASD_OP_MINUS_ONE) b = 16'h0001;
    if (o == ASD_OP_TWOS_COMPLEMENT) begin
      b = a;
      a = 16'h0000;
    end
    x = ad ? {1'b0, a} + {1'b0, b} + ci : {1'b0, a} - {1'b0, b} - ci;
    r = x[15:0] & m;
    n[ASD_FL_CARRY] = x[t+1];
    n[ASD_FL_HALF] = a[4] ^ b[4] ^ x[4];
    n[ASD_FL_OVF] = (a[t] ^ x[t]) & (a[t] ^ b[t] ^ ad);
    if (o == ASD_OP_INC || o == ASD_OP_MINUS_ONE) n[ASD_FL_CARRY] = f[ASD_FL_CARRY];
    if (o == ASD_OP_UNPACKED_SUM_ADJUST || o == ASD_OP_PACKED_SUM_ADJUST) begin
      n = f;
      lo = lb[3:0] > ASD_NIB_MAX || f[ASD_FL_HALF];
      hi = lb > ASD_PACK_HI_MAX || f[ASD_FL_CARRY];
      r = {8'h00, lb + (lo ? ASD_LO_FIX : 8'h00) + (hi ? ASD_HI_FIX : 8'h00)};
      n[ASD_FL_HALF] = lo;
      n[ASD_FL_CARRY] = hi;
      if (o == ASD_OP_UNPACKED_SUM_ADJUST) begin
        r = {12'h000, lb[3:0] + (lo ? 4'h6 : 4'h0)};
        n[ASD_FL_CARRY] = lo;
        return {r, n};
      end
      t = 7;
    end
    n[ASD_FL_SIGN] = r[t];
    n[ASD_FL_ZERO] = (r == 16'h0000);
    n[ASD_FL_PARITY] = ~^r[7:0];
    if (o == ASD_OP_COMPARE) r = r0;
    return {r, n};
  endfunction : ref_op

  // ****************
  // Check and drive
  // ****************
  task automatic check(logic [15:0] seen, logic [15:0] exp, string what);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  // Checks the op launched one edge earlier, then books the one launched now
  task automatic run(asd_op_t o, logic w, logic [15:0] d, logic [15:0] s, logic [7:0] lb,
                     logic v = 1'b1);
    logic [21:0] q;
    @(posedge clk_i);
    seq.drive(v, o, w, d, s, lb);
    #1;
    check({15'h0, done}, {15'h0, pend}, "done");
    check({15'h0, we}, {15'h0, pend_we}, "write enable");
    check(res, exp_r, "result");
    check({10'h0, fl}, {10'h0, exp_f}, "flags");
    pend = v;
    pend_we = v && o != ASD_OP_COMPARE;
    if (v) begin
      q = ref_op(o, w, d, s, lb, exp_f, exp_r);
      exp_r = q[21:6];
      exp_f = q[5:0];
    end
  endtask : run

  task automatic idle();
    run(ASD_OP_ADD, 1'b0, 16'h0000, 16'h0000, 8'h00, 1'b0);
  endtask : idle

  // ****************
  // Scenarios
  // ****************
  task automatic t_add();
    run(ASD_OP_ADD, 1'b0, 16'h017f, 16'hff01, 8'h00);
    run(ASD_OP_ADD, 1'b1, 16'hffff, 16'h0001, 8'h00);
    run(ASD_OP_ADC, 1'b1, 16'h0001, 16'h0002, 8'h00);
    run(asd_op_t'(4'ha), 1'b0, 16'h0033, 16'h0044, 8'h00);
    idle();
  endtask : t_add

  task automatic t_inc_minus();
    run(ASD_OP_ADD, 1'b1, 16'hffff, 16'h0001, 8'h00);
    run(ASD_OP_INC, 1'b0, 16'h00ff, 16'h1234, 8'h00);
    run(ASD_OP_MINUS_ONE, 1'b1, 16'h8000, 16'h0000, 8'h00);
    run(ASD_OP_ADD, 1'b0, 16'h0000, 16'h0000, 8'h00);
    run(ASD_OP_MINUS_ONE, 1'b0, 16'h0000, 16'h0000, 8'h00);
    idle();
  endtask : t_inc_minus

  task automatic t_sub();
    run(ASD_OP_SUB, 1'b0, 16'h0010, 16'h0001, 8'h00);
    run(ASD_OP_SUB, 1'b0, 16'h0000, 16'h0001, 8'h00);
    run(ASD_OP_DIFFERENCE_WITH_BORROW_IN, 1'b1, 16'h0005, 16'h0002, 8'h00);
    run(ASD_OP_COMPARE, 1'b1, 16'h8000, 16'h0001, 8'h00);
    idle();
    idle();
    check(seq.wb_reg, 16'h0002, "write-back after compare");
  endtask : t_sub

  task automatic t_negate();
    run(ASD_OP_TWOS_COMPLEMENT, 1'b0, 16'h0080, 16'h0000, 8'h00);
    run(ASD_OP_TWOS_COMPLEMENT, 1'b1, 16'h8000, 16'h0000, 8'h00);
    run(ASD_OP_TWOS_COMPLEMENT, 1'b1, 16'h0000, 16'h0000, 8'h00);
    run(ASD_OP_TWOS_COMPLEMENT, 1'b0, 16'h0005, 16'h0000, 8'h00);
    idle();
  endtask : t_negate

  task automatic t_bcd();
    run(ASD_OP_ADD, 1'b0, 16'h0038, 16'h0039, 8'h00);
    run(ASD_OP_PACKED_SUM_ADJUST, 1'b0, 16'h0000, 16'h0000, 8'h71);
    run(ASD_OP_PACKED_SUM_ADJUST, 1'b0, 16'h0000, 16'h0000, 8'h9a);
    run(ASD_OP_ADD, 1'b0, 16'h0f08, 16'h00f9, 8'h00);
    run(ASD_OP_UNPACKED_SUM_ADJUST, 1'b0, 16'h0000, 16'h0000, 8'h31);
    run(ASD_OP_UNPACKED_SUM_ADJUST, 1'b0, 16'h0000, 16'h0000, 8'h34);
    idle();
  endtask : t_bcd

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // About 50 cycles of work with reset; give it twenty-four times that
  initial begin
    #6000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    rst_n_i = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    exp_f = ASD_FLAGS_RST;
    exp_r = ASD_RES_RST;
    pend = 1'b0;
    pend_we = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    idle();
    t_add();
    t_inc_minus();
    t_sub();
    t_negate();
    t_bcd();
    wrap_up();
  end
endmodule : test_add_sub_decimal_alu_flags
